// file: rtl/socket_system_control_low.sv
/*
 * bits 21..0 of the socket system control register, reached by
 * configuration read/write at its dword offset.
 * assumes config strobes are one-cycle pulses synchronous to core_clk_i,
 * and status inputs come from the power switch engine and card logic.
 */
// Overview of operation
// - bit 21 set disables card supply protection
// - bit 15 permits downstream read bursts
// - bit 14 permits upstream read bursts
// - bit 13 card activity, cleared by read
// - bit 12 reads one, 7 and 3 zero
// - bit 11 busy during stream and delay
// - bit 10 power-up settling in progress
// - bit 9 power-down settling in progress
// - bit 8 card interrogation in progress
// - bit 6 enables low power mode
// - bit 5 locks identity registers
// - bit 4 routes card parity to SERR
// - bit 2 shows legacy supply selection
// - bit 1 keeps bus and card clocks
// - bit 0 routes wake event to pin
// - else ring output or tri-state
// - global reset only for most bits
// - context bits reset depends on wake
`timescale 1ns/100ps
`include "sysctl_params.svh"
module socket_system_control_low #(
   parameter int REG_WIDTH = 22
) (
   input  wire logic                core_clk_i,
   input  wire logic                srst_i,
   input  wire logic                global_reset_n_i,
   input  wire logic                host_bus_reset_n_i,
   input  wire logic                wake_enable_i,
   input  wire logic                cfg_write_i,
   input  wire logic                cfg_read_i,
   input  wire logic [7:0]          cfg_addr_i,
   input  wire logic [3:0]          cfg_byte_en_i,
   input  wire logic [31:0]         cfg_wdata_i,
   output logic [31:0]              cfg_rdata_o,
   output logic                     cfg_hit_o,
   input  wire logic                card_access_i,
   input  wire sysctl_pkg::status_t status_i,
   input  wire logic                ring_output_enable_i,
   input  wire logic                pm_event_i,
   input  wire logic                ring_indicate_output_i,
   input  wire logic                card_parity_error_i,
   output sysctl_pkg::ctrl_t        ctrl_o,
   output logic                     card_parity_serr_o,
   output logic                     clkrun_hold_o,
   output logic                     shared_wake_ring_pin_o,
   output logic                     shared_wake_ring_pin_oe_n_o
);
   // register layout fixes the width
   if (REG_WIDTH != 22) begin : g_bad_width
      $error("REG_WIDTH must be 22");
   end

   logic [21:0] rw_q;
   logic [21:0] wr_mask;
   logic [21:0] image;
   logic        activity_q;
   logic [2:0]  ctx_bits;
   logic        ctx_live_q;
   logic        hit;
   logic        rd_hit;
   logic        wr_hit;
   logic [31:0] rdata_q;

   function automatic logic [21:0] lane_mask(input logic [3:0] be);
      lane_mask = {{6{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   assign hit    = (cfg_addr_i == `SYSCTL_OFFSET);
   assign rd_hit = hit && cfg_read_i;
   assign wr_hit = hit && cfg_write_i;
   assign wr_mask = lane_mask(cfg_byte_en_i) & `SYSCTL_RW_MASK;

   always_ff @(posedge core_clk_i) begin
      if (srst_i || !global_reset_n_i) begin
         rw_q <= `SYSCTL_RESET_LOW & `SYSCTL_RW_MASK;
      end else if (wr_hit) begin
         rw_q <= (rw_q & ~wr_mask) | (cfg_wdata_i[21:0] & wr_mask);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i || !global_reset_n_i) begin
         activity_q <= 1'b0;
      end else if (card_access_i) begin
         activity_q <= 1'b1;
      end else if (rd_hit && cfg_byte_en_i[1]) begin
         activity_q <= 1'b0;
      end
   end

   sysctl_context_bits u_ctx (
      .core_clk_i         (core_clk_i),
      .srst_i             (srst_i),
      .global_reset_n_i   (global_reset_n_i),
      .host_bus_reset_n_i (host_bus_reset_n_i),
      .wake_enable_i      (wake_enable_i),
      .status_i           (status_i),
      .context_o          (ctx_bits)
   );

   always_comb begin
      image = rw_q;
      image[`BIT_ACTIVITY] = activity_q;
      image[`BIT_ONE] = 1'b1;
      image[`BIT_ZERO_HI] = 1'b0;
      image[`BIT_ZERO_LO] = 1'b0;
      image[`BIT_STREAM] = status_i.switch_stream_busy;
      image[`BIT_UP_SETTLE] = ctx_bits[2];
      image[`BIT_DOWN_SETTLE] = ctx_bits[1];
      image[`BIT_PROBE] = ctx_bits[0];
      image[`BIT_LEGACY_SUPPLY] = status_i.legacy_supply_select;
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_hit) begin
         rdata_q <= {10'h000, image};
      end
   end
   assign cfg_rdata_o = rdata_q;
   assign cfg_hit_o   = hit;

   assign ctrl_o.read_burst_downstream_en = rw_q[`BIT_BURST_DN];
   assign ctrl_o.read_burst_upstream_en   = rw_q[`BIT_BURST_UP];
   assign ctrl_o.supply_protect_dis       = rw_q[`BIT_SUPPLY_PROT];
   assign ctrl_o.low_power_mode_en        = rw_q[`BIT_LOW_POWER];
   assign ctrl_o.identity_write_lock      = rw_q[`BIT_ID_LOCK];
   assign ctrl_o.card_parity_serr_en      = rw_q[`BIT_PARITY_SERR];
   assign ctrl_o.hold_clocks_running      = rw_q[`BIT_HOLD_CLK];
   assign ctrl_o.wake_ring_pin_select     = rw_q[`BIT_PIN_SELECT];

   assign card_parity_serr_o = card_parity_error_i && rw_q[`BIT_PARITY_SERR];
   assign clkrun_hold_o      = rw_q[`BIT_HOLD_CLK];

   sysctl_pin_mux u_pin (
      .core_clk_i                  (core_clk_i),
      .srst_i                      (srst_i),
      .pin_select_i                (rw_q[`BIT_PIN_SELECT]),
      .ring_output_enable_i        (ring_output_enable_i),
      .pm_event_i                  (pm_event_i),
      .ring_indicate_output_i      (ring_indicate_output_i),
      .shared_wake_ring_pin_o      (shared_wake_ring_pin_o),
      .shared_wake_ring_pin_oe_n_o (shared_wake_ring_pin_oe_n_o)
   );

   // context reads only checked when no clear was pending
   always_ff @(posedge core_clk_i) begin
      ctx_live_q <= !srst_i && global_reset_n_i && host_bus_reset_n_i;
   end

   a_act_keep_set: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (card_access_i && global_reset_n_i) |=> activity_q)
      else $error("card activity lost");

   a_act_read_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (rd_hit && cfg_byte_en_i[1] && !card_access_i) |=> !activity_q)
      else $error("activity flag not cleared by read");

   a_rsvd_fixed: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $past(rd_hit) |-> (cfg_rdata_o[12] && !cfg_rdata_o[7] && !cfg_rdata_o[3]))
      else $error("reserved bits read wrong");

   a_global_reset_n_default: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !global_reset_n_i |=> (rw_q == (`SYSCTL_RESET_LOW & `SYSCTL_RW_MASK)))
      else $error("global reset did not restore defaults");

   a_host_bus_reset_n_keeps: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (global_reset_n_i && !host_bus_reset_n_i && !wr_hit) |=> $stable(rw_q))
      else $error("host reset disturbed control bits");

   a_stream_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
      rd_hit |=> (cfg_rdata_o[11] == $past(status_i.switch_stream_busy)))
      else $error("stream busy not reported");

   a_serr_gate: assert property (@(posedge core_clk_i) disable iff (srst_i)
      card_parity_serr_o |-> ctrl_o.card_parity_serr_en)
      else $error("parity reported while disabled");

   a_write_burst: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (wr_hit && cfg_byte_en_i[1] && global_reset_n_i)
      |=> (ctrl_o.read_burst_downstream_en == $past(cfg_wdata_i[15])))
      else $error("downstream burst bit not written");

   a_write_prot: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (wr_hit && cfg_byte_en_i[2] && global_reset_n_i)
      |=> (ctrl_o.supply_protect_dis == $past(cfg_wdata_i[`BIT_SUPPLY_PROT])))
      else $error("supply protection bit not written");

   a_write_burst_up: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (wr_hit && cfg_byte_en_i[1] && global_reset_n_i)
      |=> (ctrl_o.read_burst_upstream_en == $past(cfg_wdata_i[`BIT_BURST_UP])))
      else $error("upstream burst bit not written");

   a_write_low_power: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (wr_hit && cfg_byte_en_i[0] && global_reset_n_i)
      |=> (ctrl_o.low_power_mode_en == $past(cfg_wdata_i[`BIT_LOW_POWER])))
      else $error("low power bit not written");

   a_write_id_lock: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (wr_hit && cfg_byte_en_i[0] && global_reset_n_i)
      |=> (ctrl_o.identity_write_lock == $past(cfg_wdata_i[`BIT_ID_LOCK])))
      else $error("identity lock bit not written");

   a_write_clk_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (wr_hit && cfg_byte_en_i[0] && global_reset_n_i)
      |=> (clkrun_hold_o == $past(cfg_wdata_i[`BIT_HOLD_CLK])))
      else $error("clock hold bit not written");

   a_write_pin_sel: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (wr_hit && cfg_byte_en_i[0] && global_reset_n_i)
      |=> (ctrl_o.wake_ring_pin_select == $past(cfg_wdata_i[`BIT_PIN_SELECT])))
      else $error("pin select bit not written");

   a_serr_pass: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (card_parity_error_i && ctrl_o.card_parity_serr_en) |-> card_parity_serr_o)
      else $error("enabled parity error not reported");

   a_serr_block: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !card_parity_error_i |-> !card_parity_serr_o)
      else $error("serr raised without parity error");

   a_act_global_reset_n_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !global_reset_n_i |=> !activity_q)
      else $error("activity kept through global reset");

   a_act_host_bus_reset_n_keep: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (global_reset_n_i && !host_bus_reset_n_i && !card_access_i && !rd_hit)
      |=> $stable(activity_q))
      else $error("host reset disturbed activity flag");

   a_up_settle_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (rd_hit && ctx_live_q)
      |=> (cfg_rdata_o[`BIT_UP_SETTLE] == $past(status_i.power_up_settling, 2)))
      else $error("power-up settling not reported");

   a_down_settle_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (rd_hit && ctx_live_q)
      |=> (cfg_rdata_o[`BIT_DOWN_SETTLE] == $past(status_i.power_down_settling, 2)))
      else $error("power-down settling not reported");

   a_probe_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (rd_hit && ctx_live_q)
      |=> (cfg_rdata_o[`BIT_PROBE] == $past(status_i.card_probe_busy, 2)))
      else $error("probe busy not reported");

   a_ctx_host_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!host_bus_reset_n_i && !wake_enable_i) |=> (ctx_bits == 3'h0))
      else $error("context bits kept on host reset without wake");

   a_ctx_global_reset_n_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !global_reset_n_i |=> (ctx_bits == 3'h0))
      else $error("context bits kept on global reset");

   a_legacy_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
      rd_hit
      |=> (cfg_rdata_o[`BIT_LEGACY_SUPPLY] == $past(status_i.legacy_supply_select)))
      else $error("legacy supply not reported");

   a_ring_route: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!rw_q[`BIT_PIN_SELECT] && ring_output_enable_i)
      |=> (!shared_wake_ring_pin_oe_n_o && shared_wake_ring_pin_o == $past(ring_indicate_output_i)))
      else $error("ring output not routed to shared pin");
endmodule // socket_system_control_low

// file: rtl/sysctl_context_bits.sv
/*
 * power-management context status flags with wake-aware reset.
 * assumes inputs synchronous to core_clk_i.
 */
`timescale 1ns/100ps
`include "sysctl_params.svh"
module sysctl_context_bits (
   input  wire logic                core_clk_i,
   input  wire logic                srst_i,
   input  wire logic                global_reset_n_i,
   input  wire logic                host_bus_reset_n_i,
   input  wire logic                wake_enable_i,
   input  wire sysctl_pkg::status_t status_i,
   output logic [2:0]               context_o
);
   logic [2:0] ctx_q;
   logic       clear_ctx;
   assign clear_ctx = srst_i || !global_reset_n_i
                      || (!host_bus_reset_n_i && !wake_enable_i);
   always_ff @(posedge core_clk_i) begin
      if (clear_ctx) begin
         ctx_q <= 3'h0;
      end else begin
         ctx_q <= {status_i.power_up_settling, status_i.power_down_settling,
                   status_i.card_probe_busy};
      end
   end
   assign context_o = ctx_q;
   a_ctx_keep_wake: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (global_reset_n_i && wake_enable_i && !host_bus_reset_n_i
       && $past(global_reset_n_i)) |=> (ctx_q == $past({status_i.power_up_settling,
       status_i.power_down_settling, status_i.card_probe_busy})))
      else $error("context bits lost on host reset while wake enabled");
endmodule // sysctl_context_bits

// file: rtl/sysctl_params.svh
/*
 * constants for the low half of the socket system control register.
 * assumes inclusion by bare name from design files.
 */
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH
`define SYSCTL_OFFSET       8'h80
`define SYSCTL_RESET_LOW    22'h00_9060
`define SYSCTL_RW_MASK      22'h3F_C073
`define BIT_SUPPLY_PROT     21
`define BIT_RSVD_HI         20
`define BIT_RSVD_LO         16
`define BIT_BURST_DN        15
`define BIT_BURST_UP        14
`define BIT_ACTIVITY        13
`define BIT_ONE             12
`define BIT_STREAM          11
`define BIT_UP_SETTLE       10
`define BIT_DOWN_SETTLE     9
`define BIT_PROBE           8
`define BIT_LOW_POWER       6
`define BIT_ID_LOCK         5
`define BIT_PARITY_SERR     4
`define BIT_LEGACY_SUPPLY   2
`define BIT_HOLD_CLK        1
`define BIT_PIN_SELECT      0
`define BIT_ZERO_HI         7
`define BIT_ZERO_LO         3
`endif

// file: rtl/sysctl_pin_mux.sv
/*
 * shared wake/ring output terminal routing.
 * assumes control bits come from the register bank.
 */
`timescale 1ns/100ps
module sysctl_pin_mux (
   input  wire logic core_clk_i,
   input  wire logic srst_i,
   input  wire logic pin_select_i,
   input  wire logic ring_output_enable_i,
   input  wire logic pm_event_i,
   input  wire logic ring_indicate_output_i,
   output logic      shared_wake_ring_pin_o,
   output logic      shared_wake_ring_pin_oe_n_o
);
   sysctl_pkg::pin_mode_t mode;
   logic                  pin_q;
   logic                  oe_n_q;
   always_comb begin
      if (pin_select_i) begin
         mode = sysctl_pkg::PIN_WAKE;
      end else if (ring_output_enable_i) begin
         mode = sysctl_pkg::PIN_RING;
      end else begin
         mode = sysctl_pkg::PIN_OFF;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pin_q  <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         unique case (mode)
            sysctl_pkg::PIN_WAKE: begin
               pin_q  <= pm_event_i;
               oe_n_q <= 1'b0;
            end
            sysctl_pkg::PIN_RING: begin
               pin_q  <= ring_indicate_output_i;
               oe_n_q <= 1'b0;
            end
            sysctl_pkg::PIN_OFF: begin
               pin_q  <= 1'b0;
               oe_n_q <= 1'b1;
            end
         endcase
      end
   end
   assign shared_wake_ring_pin_o      = pin_q;
   assign shared_wake_ring_pin_oe_n_o = oe_n_q;
   a_pin_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!pin_select_i && !ring_output_enable_i) |=> shared_wake_ring_pin_oe_n_o)
      else $error("shared pin driven while both routes disabled");
   a_pin_wake: assert property (@(posedge core_clk_i) disable iff (srst_i)
      pin_select_i |=> (!shared_wake_ring_pin_oe_n_o
                        && shared_wake_ring_pin_o == $past(pm_event_i)))
      else $error("wake event not routed to shared pin");
endmodule // sysctl_pin_mux

// file: rtl/sysctl_pkg.sv
/*
 * types shared by the system control register files.
 * assumes sysctl_params.svh for bit positions.
 */
package sysctl_pkg;
   typedef struct packed {
      logic       supply_protect_dis;
      logic       read_burst_downstream_en;
      logic       read_burst_upstream_en;
      logic       low_power_mode_en;
      logic       identity_write_lock;
      logic       card_parity_serr_en;
      logic       hold_clocks_running;
      logic       wake_ring_pin_select;
   } ctrl_t;
   typedef struct packed {
      logic       switch_stream_busy;
      logic       power_up_settling;
      logic       power_down_settling;
      logic       card_probe_busy;
      logic       legacy_supply_select;
   } status_t;
   typedef enum logic [2:0] {
      PIN_OFF  = 3'b001,
      PIN_WAKE = 3'b010,
      PIN_RING = 3'b100
   } pin_mode_t;
endpackage

// file: verification/socket_system_control_low_test.sv
/*
 * self-checking bench for the low system control register bits.
 * assumes the host model drives all configuration strobes.
 */
`timescale 1ns/100ps
module socket_system_control_low_test;
   typedef struct {logic [3:0] be; logic [31:0] wd; logic [31:0] ex;} row_t;
   logic core_clk_i = 1'b0, srst_i, global_reset_n_i, host_bus_reset_n_i, wake_enable_i;
   logic cfg_write_i, cfg_read_i, cfg_hit_o, card_access_i, ring_output_enable_i;
   logic pm_event_i, ring_indicate_output_i, card_parity_error_i, card_parity_serr_o;
   logic clkrun_hold_o, shared_wake_ring_pin_o, shared_wake_ring_pin_oe_n_o;
   logic [7:0] cfg_addr_i;
   logic [3:0] cfg_byte_en_i;
   logic [31:0] cfg_wdata_i, cfg_rdata_o, v, e;
   sysctl_pkg::status_t status_i;
   sysctl_pkg::ctrl_t ctrl_o;
   int n_mismatch = 0, total_checks = 0, cycles = 0;
   row_t rows [6] = '{'{4'hF, 32'hFFE0_FFFF, 32'h0020_D073}, '{4'hF, 32'h0, 32'h0000_1000},
      '{4'h4, 32'h0020_0000, 32'h0020_1000}, '{4'h2, 32'h0000_C000, 32'h0020_D000},
      '{4'h1, 32'h0000_00FF, 32'h0020_D073}, '{4'h3, 32'h0, 32'h0020_1000}};
   always #50 core_clk_i = ~core_clk_i;
   socket_system_control_low i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .global_reset_n_i(global_reset_n_i), .host_bus_reset_n_i(host_bus_reset_n_i),
      .wake_enable_i(wake_enable_i), .cfg_write_i(cfg_write_i), .cfg_read_i(cfg_read_i),
      .cfg_addr_i(cfg_addr_i), .cfg_byte_en_i(cfg_byte_en_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o), .card_access_i(card_access_i),
      .status_i(status_i), .ring_output_enable_i(ring_output_enable_i),
      .pm_event_i(pm_event_i), .ring_indicate_output_i(ring_indicate_output_i),
      .card_parity_error_i(card_parity_error_i), .ctrl_o(ctrl_o),
      .card_parity_serr_o(card_parity_serr_o), .clkrun_hold_o(clkrun_hold_o),
      .shared_wake_ring_pin_o(shared_wake_ring_pin_o),
      .shared_wake_ring_pin_oe_n_o(shared_wake_ring_pin_oe_n_o));
   sysctl_host_model i_host (.core_clk_i(core_clk_i), .cfg_rdata_i(cfg_rdata_o),
      .cfg_write_o(cfg_write_i), .cfg_read_o(cfg_read_i), .cfg_addr_o(cfg_addr_i),
      .cfg_byte_en_o(cfg_byte_en_i), .cfg_wdata_o(cfg_wdata_i));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] ex);
      total_checks++;
      if (seen !== ex) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, ex, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic rd_chk(input string name, input logic [31:0] ex);
      i_host.rd(8'h80, v);
      check(name, v, ex);
   endtask
   initial begin
      {srst_i, global_reset_n_i, host_bus_reset_n_i, card_parity_error_i} = 4'b1111;
      {wake_enable_i, card_access_i, ring_output_enable_i} = 3'b000;
      {pm_event_i, ring_indicate_output_i} = 2'b00;
      status_i = '0;
      repeat (4) @(negedge core_clk_i);
      srst_i = 1'b0;
      rd_chk("reset image", 32'h0000_9060);
      check("pin oe_n", 32'(shared_wake_ring_pin_oe_n_o), 32'h1);
      $display("test reset done");
      foreach (rows[i]) begin
         e = rows[i].ex;
         card_parity_error_i = (i != 4);
         i_host.wr(8'h80, rows[i].be, rows[i].wd);
         rd_chk("readback", e);
         check("ctrl", 32'(ctrl_o), {24'h0, e[21], e[15:14], e[6:4], e[1:0]});
         check("serr", 32'(card_parity_serr_o), 32'(e[4] && i != 4));
         check("clkrun", 32'(clkrun_hold_o), 32'(e[1]));
      end
      $display("test table done");
      i_host.rd(8'h84, v);
      check("unmapped read", cfg_rdata_o, 32'h0020_1000);
      i_host.wr(8'h84, 4'hF, 32'hFFE0_FFFF);
      rd_chk("unmapped write", 32'h0020_1000);
      card_access_i = 1'b1;
      @(negedge core_clk_i) card_access_i = 1'b0;
      rd_chk("activity set", 32'h0020_3000);
      rd_chk("activity clear", 32'h0020_1000);
      fork
         i_host.rd(8'h80, v);
         begin
            @(negedge core_clk_i) card_access_i = 1'b1;
            @(posedge core_clk_i) check("cfg hit", 32'(cfg_hit_o), 32'h1);
            @(negedge core_clk_i) card_access_i = 1'b0;
         end
      join
      check("read with access", v, 32'h0020_1000);
      rd_chk("activity kept", 32'h0020_3000);
      $display("test activity done");
      status_i = 5'b1_1111;
      repeat (2) @(negedge core_clk_i);
      rd_chk("status", 32'h0020_1F04);
      host_bus_reset_n_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rd_chk("host reset no wake", 32'h0020_1804);
      wake_enable_i = 1'b1;
      host_bus_reset_n_i = 1'b1;
      repeat (2) @(negedge core_clk_i) host_bus_reset_n_i = 1'b0;
      rd_chk("host reset wake", 32'h0020_1F04);
      host_bus_reset_n_i = 1'b1;
      status_i = '0;
      repeat (2) @(negedge core_clk_i);
      rd_chk("status idle", 32'h0020_1000);
      global_reset_n_i = 1'b0;
      @(negedge core_clk_i) global_reset_n_i = 1'b1;
      rd_chk("global reset", 32'h0000_9060);
      $display("test resets done");
      for (int i = 0; i < 4; i++) begin
         ring_output_enable_i = (i == 1 || i == 2);
         pm_event_i = (i == 0 || i == 3);
         ring_indicate_output_i = (i != 0);
         i_host.wr_keep(4'h1, 32'(i < 2));
         repeat (2) @(negedge core_clk_i);
         check("oe_n", 32'(shared_wake_ring_pin_oe_n_o), 32'(i == 3));
         if (i < 2) check("wake pin", 32'(shared_wake_ring_pin_o), 32'(i == 0));
         if (i == 2) check("ring pin", 32'(shared_wake_ring_pin_o), 32'h1);
      end
      $display("test pin done");
      print_verdict();
   end
endmodule // socket_system_control_low_test

// file: verification/sysctl_host_model.sv
/*
 * host model issuing configuration reads and writes to the register.
 * assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/100ps
module sysctl_host_model (
   input  wire logic        core_clk_i,
   input  wire logic [31:0] cfg_rdata_i,
   output logic             cfg_write_o,
   output logic             cfg_read_o,
   output logic [7:0]       cfg_addr_o,
   output logic [3:0]       cfg_byte_en_o,
   output logic [31:0]      cfg_wdata_o
);
   initial begin
      cfg_write_o = 1'b0;
      cfg_read_o = 1'b0;
      cfg_addr_o = 8'h00;
      cfg_byte_en_o = 4'h0;
      cfg_wdata_o = 32'h0000_0000;
   end
   // released qualifiers go inverted, never stale
   task automatic drop();
      @(negedge core_clk_i);
      cfg_write_o = 1'b0;
      cfg_read_o = 1'b0;
      cfg_addr_o = ~cfg_addr_o;
      cfg_byte_en_o = ~cfg_byte_en_o;
      cfg_wdata_o = ~cfg_wdata_o;
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge core_clk_i);
      cfg_addr_o = a;
      cfg_byte_en_o = be;
      cfg_wdata_o = d;
      cfg_write_o = 1'b1;
      drop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge core_clk_i);
      cfg_addr_o = a;
      cfg_byte_en_o = 4'hF;
      cfg_read_o = 1'b1;
      drop();
      d = cfg_rdata_i;
   endtask
   task automatic wr_keep(input logic [3:0] be, input logic [31:0] d);
      logic [31:0] v;
      rd(8'h80, v);
      wr(8'h80, be, (d & ~32'h001F_0000) | (v & 32'h001F_0000));
   endtask
endmodule // sysctl_host_model
